// file: src/pcg_pkg.sv
package pcg_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam int unsigned PCG_AW = 12;
  localparam logic [11:0] PCG_OFS_RUN_PORT   = 12'h108;
  localparam logic [11:0] PCG_OFS_SLEEP_PORT = 12'h118;
  localparam logic [11:0] PCG_OFS_DEEP_UNIT  = 12'h124;
  localparam logic [11:0] PCG_OFS_DEEP_PORT  = 12'h128;
  localparam logic [11:0] PCG_OFS_RUN_CFG    = 12'h1F0;

  // ==========================================================
  // field layout
  localparam int unsigned PCG_NUM_PORT = 8;
  localparam int unsigned PCG_NUM_SER  = 4;
  localparam int unsigned PCG_NUM_UNIT = 12;
  localparam int unsigned PCG_BIT_ASER0 = 0;
  localparam int unsigned PCG_BIT_ASER1 = 1;
  localparam int unsigned PCG_BIT_SSER0 = 4;
  localparam int unsigned PCG_BIT_WIRE0 = 12;
  localparam int unsigned PCG_BIT_AUTO  = 0;
  localparam int unsigned PCG_IDX_SER   = 8;

  // ==========================================================
  // reset values and bus answers
  localparam logic [7:0]  PCG_PORT_RST = 8'h00;
  localparam logic [3:0]  PCG_SER_RST  = 4'h0;
  localparam logic [31:0] PCG_ZERO32   = 32'h0000_0000;
  localparam logic [1:0]  PCG_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PCG_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    PCG_MODE_RUN,
    PCG_MODE_SLEEP,
    PCG_MODE_DEEP
  } pcg_mode_e;

  typedef logic [PCG_NUM_UNIT-1:0] pcg_gate_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] unit;
  } pcg_access_s;

  typedef struct packed {
    logic done;
    logic fault;
  } pcg_answer_s;

endpackage : pcg_pkg

// file: src/pcg_unit_gate.sv
`timescale 1ns/1ps
module pcg_unit_gate (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               run_bit,
  input  wire logic               sleep_bit,
  input  wire logic               deep_bit,
  input  wire logic               auto_gate,
  input  wire pcg_pkg::pcg_mode_e mode,
  output logic                    gate_en
);
  import pcg_pkg::*;

  logic next_gate_en;

  // ==========================================================
  // source selection by power mode
  always_comb begin
    next_gate_en = run_bit;
    if (auto_gate) begin
      case (mode)
        PCG_MODE_SLEEP: next_gate_en = sleep_bit;
        PCG_MODE_DEEP:  next_gate_en = deep_bit;
        default:        next_gate_en = run_bit;
      endcase
    end
  end

  // registered so the enable never glitches
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_en <= 1'b0;
    end else begin
      gate_en <= next_gate_en;
    end
  end

endmodule : pcg_unit_gate

// file: src/pcg_access_check.sv
`timescale 1ns/1ps
module pcg_access_check (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire pcg_pkg::pcg_access_s req,
  input  wire pcg_pkg::pcg_gate_t   gate,
  output pcg_pkg::pcg_answer_s      ans
);
  import pcg_pkg::*;

  logic open_unit;

  // unit numbers with no unit behind them always fault
  assign open_unit = (32'(req.unit) < PCG_NUM_UNIT) && gate[req.unit];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ans <= '0;
    end else begin
      ans.done  <= req.valid;
      ans.fault <= req.valid && !open_unit;
    end
  end

endmodule : pcg_access_check

// file: src/pcg_top.sv
`timescale 1ns/1ps
module pcg_top (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic [11:0]              avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic      [1:0]               avs_response,
  output logic                          avs_waitrequest,
  input  wire logic                     sleep_req,
  input  wire logic                     deep_sleep_req,
  input  wire logic [3:0]               run_unit_gate,
  input  wire logic [3:0]               sleep_unit_gate,
  input  wire pcg_pkg::pcg_access_s     per_req,
  output pcg_pkg::pcg_answer_s          per_ans,
  output pcg_pkg::pcg_gate_t            gate_en,
  output pcg_pkg::pcg_mode_e            power_mode
);
  import pcg_pkg::*;

  // ==========================================================
  // registers
  logic [7:0]  run_port_clock_gate;
  logic [7:0]  sleep_port_clock_gate;
  logic [7:0]  deep_sleep_port_clock_gate;
  logic [3:0]  deep_sleep_unit_gate;
  logic        auto_sleep_gating_select;

  logic        bus_req;
  logic        bus_take;
  logic        hit_run;
  logic        hit_sleep;
  logic        hit_dunit;
  logic        hit_dport;
  logic        hit_cfg;
  logic        mapped;
  logic [31:0] wr_merge;
  logic [31:0] rd_value;
  logic [31:0] cur_value;
  logic [31:0] bmask;
  logic [3:0]  wr_ser;
  logic [7:0]  run_src;
  logic [7:0]  sleep_src;
  logic [7:0]  deep_src;
  pcg_mode_e   next_mode;

  // ==========================================================
  // address decode
  assign bus_req   = avs_read || avs_write;
  assign bus_take  = bus_req && avs_waitrequest;
  assign hit_run   = avs_address == PCG_OFS_RUN_PORT;
  assign hit_sleep = avs_address == PCG_OFS_SLEEP_PORT;
  assign hit_dunit = avs_address == PCG_OFS_DEEP_UNIT;
  assign hit_dport = avs_address == PCG_OFS_DEEP_PORT;
  assign hit_cfg   = avs_address == PCG_OFS_RUN_CFG;
  assign mapped    = hit_run || hit_sleep || hit_dunit || hit_dport
                     || hit_cfg;

  // ==========================================================
  // read values; only implemented bits are driven
  always_comb begin
    rd_value = PCG_ZERO32;
    if (hit_run) begin
      rd_value[7:0] = run_port_clock_gate;
    end else if (hit_sleep) begin
      rd_value[7:0] = sleep_port_clock_gate;
    end else if (hit_dport) begin
      rd_value[7:0] = deep_sleep_port_clock_gate;
    end else if (hit_dunit) begin
      rd_value[PCG_BIT_ASER0] = deep_sleep_unit_gate[0];
      rd_value[PCG_BIT_ASER1] = deep_sleep_unit_gate[1];
      rd_value[PCG_BIT_SSER0] = deep_sleep_unit_gate[2];
      rd_value[PCG_BIT_WIRE0] = deep_sleep_unit_gate[3];
    end else if (hit_cfg) begin
      rd_value[PCG_BIT_AUTO] = auto_sleep_gating_select;
    end
  end

  // byte lanes merge new data over the present contents
  always_comb begin
    cur_value = rd_value;
    for (int b = 0; b < 4; b++) begin
      bmask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
    wr_merge = (avs_writedata & bmask) | (cur_value & ~bmask);
    wr_ser   = {wr_merge[PCG_BIT_WIRE0], wr_merge[PCG_BIT_SSER0],
                wr_merge[PCG_BIT_ASER1], wr_merge[PCG_BIT_ASER0]};
  end

  // ==========================================================
  // bus answer: one wait cycle, then the answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_take;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= PCG_ZERO32;
      avs_response <= PCG_RESP_OKAY;
    end else if (bus_take) begin
      avs_readdata <= avs_read ? rd_value : PCG_ZERO32;
      avs_response <= mapped ? PCG_RESP_OKAY : PCG_RESP_DECERR;
    end
  end

  // ==========================================================
  // gate registers; reserved positions are never stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_port_clock_gate <= PCG_PORT_RST;
    end else if (bus_take && avs_write && hit_run) begin
      run_port_clock_gate <= wr_merge[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_port_clock_gate <= PCG_PORT_RST;
    end else if (bus_take && avs_write && hit_sleep) begin
      sleep_port_clock_gate <= wr_merge[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      deep_sleep_port_clock_gate <= PCG_PORT_RST;
    end else if (bus_take && avs_write && hit_dport) begin
      deep_sleep_port_clock_gate <= wr_merge[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      deep_sleep_unit_gate <= PCG_SER_RST;
    end else if (bus_take && avs_write && hit_dunit) begin
      deep_sleep_unit_gate <= wr_ser;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      auto_sleep_gating_select <= 1'b0;
    end else if (bus_take && avs_write && hit_cfg) begin
      auto_sleep_gating_select <= wr_merge[PCG_BIT_AUTO];
    end
  end

  // ==========================================================
  // power mode, deep sleep wins over sleep
  always_comb begin
    next_mode = PCG_MODE_RUN;
    if (deep_sleep_req) begin
      next_mode = PCG_MODE_DEEP;
    end else if (sleep_req) begin
      next_mode = PCG_MODE_SLEEP;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_mode <= PCG_MODE_RUN;
    end else begin
      power_mode <= next_mode;
    end
  end

  // ==========================================================
  // per-unit enables
  assign run_src   = run_port_clock_gate;
  assign sleep_src = sleep_port_clock_gate;
  assign deep_src  = deep_sleep_port_clock_gate;

  for (genvar i = 0; i < PCG_NUM_PORT; i++) begin : g_port
    pcg_unit_gate u_gate (
      .mclk      (mclk),
      .rst       (rst),
      .run_bit   (run_src[i]),
      .sleep_bit (sleep_src[i]),
      .deep_bit  (deep_src[i]),
      .auto_gate (auto_sleep_gating_select),
      .mode      (power_mode),
      .gate_en   (gate_en[i])
    );
  end

  for (genvar j = 0; j < PCG_NUM_SER; j++) begin : g_ser
    pcg_unit_gate u_gate (
      .mclk      (mclk),
      .rst       (rst),
      .run_bit   (run_unit_gate[j]),
      .sleep_bit (sleep_unit_gate[j]),
      .deep_bit  (deep_sleep_unit_gate[j]),
      .auto_gate (auto_sleep_gating_select),
      .mode      (power_mode),
      .gate_en   (gate_en[PCG_IDX_SER+j])
    );
  end

  // ==========================================================
  // fault answers for peripheral accesses
  pcg_access_check u_check (
    .mclk (mclk),
    .rst  (rst),
    .req  (per_req),
    .gate (gate_en),
    .ans  (per_ans)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_run_write;
    bus_take && avs_write && hit_run && avs_byteenable[0];
  endsequence

  sequence s_bus_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_reset_all_off: assert property (
    $fell(rst) |-> (run_port_clock_gate == PCG_PORT_RST)
      && (sleep_port_clock_gate == PCG_PORT_RST)
      && (deep_sleep_unit_gate == PCG_SER_RST) && (gate_en == '0))
    else $error("gate state not cleared by reset");

  a_run_write_store: assert property (
    s_run_write |=> run_port_clock_gate == $past(avs_writedata[7:0]))
    else $error("run gate write not stored");

  a_run_sel_gate: assert property (
    !auto_sleep_gating_select |=>
      gate_en[7:0] == $past(run_port_clock_gate))
    else $error("run gating not applied without auto gating");

  a_sleep_sel_gate: assert property (
    auto_sleep_gating_select && power_mode == PCG_MODE_SLEEP |=>
      gate_en[7:0] == $past(sleep_port_clock_gate))
    else $error("sleep gating not applied");

  a_deep_sel_gate: assert property (
    auto_sleep_gating_select && power_mode == PCG_MODE_DEEP |=>
      gate_en == {$past(deep_sleep_unit_gate),
                  $past(deep_sleep_port_clock_gate)})
    else $error("deep-sleep gating not applied");

  a_write_reach_gate: assert property (
    s_run_write ##0 !auto_sleep_gating_select
      ##1 !auto_sleep_gating_select |=>
      gate_en[7:0] == $past(avs_writedata[7:0], 2))
    else $error("gate change late");

  a_fault_closed: assert property (
    per_req.valid && (32'(per_req.unit) >= PCG_NUM_UNIT
      || !gate_en[per_req.unit]) |=> per_ans.done && per_ans.fault)
    else $error("access to unclocked unit not faulted");

  a_access_open: assert property (
    per_req.valid && 32'(per_req.unit) < PCG_NUM_UNIT
      && gate_en[per_req.unit] |=> per_ans.done && !per_ans.fault)
    else $error("access to clocked unit faulted");

  a_port_reserved: assert property (
    bus_take && avs_read && (hit_run || hit_sleep || hit_dport) |=>
      avs_readdata[31:8] == '0)
    else $error("reserved port bits read nonzero");

  a_ser_reserved: assert property (
    bus_take && avs_read && hit_dunit |=>
      avs_readdata[11:5] == '0 && avs_readdata[3:2] == '0
      && avs_readdata[31:13] == '0)
    else $error("reserved unit bits read nonzero");

  a_bus_one_wait: assert property (
    bus_take |=> s_bus_answer)
    else $error("bus answer not after one wait cycle");

endmodule : pcg_top

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  logic        mclk, rst, avs_read, avs_write, sleep_req, deep_sleep_req;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, du_r, v;
  logic [3:0]  avs_byteenable, run_unit_gate, sleep_unit_gate;
  logic [1:0]  avs_response;
  logic        avs_waitrequest, auto_r;
  pcg_access_s per_req;
  pcg_answer_s per_ans;
  pcg_gate_t   gate_en;
  pcg_mode_e   power_mode;
  logic [7:0]  run_r, slp_r, dp_r;
  logic [33:0] rd_q[$];
  logic        ans_q[$];
  int          n_mismatch, checked, cyc;
  logic [11:0] ofs[5];
  logic [31:0] msk[5];

  pcg_top i_pcg_top (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .run_unit_gate(run_unit_gate),
    .sleep_unit_gate(sleep_unit_gate), .per_req(per_req),
    .per_ans(per_ans), .gate_en(gate_en), .power_mode(power_mode));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================================
  // checking
  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) bad($sformatf("read %h exp %h", g, e));
  endtask : cmp_rd

  task automatic cmp_ans(input logic e, input logic g);
    checked++;
    if (g !== e) bad($sformatf("fault %b exp %b", g, e));
  endtask : cmp_ans

  task automatic cmp_gate(input pcg_gate_t e, input pcg_mode_e m);
    checked++;
    if (gate_en !== e || power_mode !== m)
      bad($sformatf("gate %h mode %0d exp %h %0d", gate_en, power_mode, e, m));
  endtask : cmp_gate

  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // monitor takes the oldest note whenever a result shows
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim();
    end else if (!rst) begin
      if (avs_read && avs_waitrequest === 1'b0)
        cmp_rd(rd_q.size() ? rd_q.pop_front() : 'x,
               {avs_response, avs_readdata});
      if (per_ans.done === 1'b1)
        cmp_ans(ans_q.size() ? ans_q.pop_front() : 1'bx,
                per_ans.fault);
    end
  end

  // ==========================================================
  // drivers
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad("no bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hF);
    bus(1'b1, a, d, be);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = PCG_RESP_OKAY);
    rd_q.push_back({r, d});
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : rd

  function automatic pcg_gate_t exp_gate();
    if (auto_r && deep_sleep_req)
      return {du_r[12], du_r[4], du_r[1], du_r[0], dp_r};
    if (auto_r && sleep_req) return {sleep_unit_gate, slp_r};
    return {run_unit_gate, run_r};
  endfunction : exp_gate

  function automatic pcg_mode_e exp_mode();
    if (deep_sleep_req) return PCG_MODE_DEEP;
    if (sleep_req) return PCG_MODE_SLEEP;
    return PCG_MODE_RUN;
  endfunction : exp_mode

  // every unit number once, back to back
  task automatic sweep;
    pcg_gate_t g;
    g = exp_gate();
    for (int u = 0; u < 16; u++) begin
      @(posedge mclk);
      per_req <= '{valid: 1'b1, write: u[0], unit: u[3:0]};
      ans_q.push_back(u >= 12 || !g[u]);
    end
    @(posedge mclk);
    per_req.valid <= 1'b0;
  endtask : sweep

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, sleep_req, deep_sleep_req, auto_r} = '0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {run_unit_gate, sleep_unit_gate, run_r, slp_r, dp_r, du_r} = '0;
    per_req = '0;
    v = $urandom(32'hE1B4);
    ofs = '{PCG_OFS_RUN_PORT, PCG_OFS_SLEEP_PORT, PCG_OFS_DEEP_UNIT,
            PCG_OFS_DEEP_PORT, PCG_OFS_RUN_CFG};
    msk = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_1013,
            32'h0000_00FF, 32'h0000_0001};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp_gate('0, PCG_MODE_RUN);
    for (int k = 0; k < 5; k++) begin
      rd(ofs[k], 32'h0000_0000);
      wr(ofs[k], 32'hFFFF_FFFF);
      rd(ofs[k], msk[k]);
      wr(ofs[k], 32'h0000_0000);
      rd(ofs[k], 32'h0000_0000);
    end
    wr(12'h200, 32'hFFFF_FFFF);
    rd(12'h200, 32'h0000_0000, PCG_RESP_DECERR);
    rd(12'h10C, 32'h0000_0000, PCG_RESP_DECERR);
    wr(PCG_OFS_RUN_PORT, 32'h0000_00A5);
    wr(PCG_OFS_RUN_PORT, 32'h0000_0000, 4'hE);
    rd(PCG_OFS_RUN_PORT, 32'h0000_00A5);
    for (int it = 0; it < 6; it++) begin
      @(posedge mclk);
      sleep_req <= 1'b0;
      deep_sleep_req <= 1'b0;
      run_unit_gate <= 4'($urandom);
      sleep_unit_gate <= 4'($urandom);
      auto_r = 1'b0;
      wr(PCG_OFS_RUN_CFG, 32'h0000_0000);
      v = $urandom;
      slp_r = v[7:0];
      wr(PCG_OFS_SLEEP_PORT, {24'h0, slp_r});
      v = $urandom;
      dp_r = v[7:0];
      wr(PCG_OFS_DEEP_PORT, {24'h0, dp_r});
      v = $urandom;
      du_r = v & 32'h0000_1013;
      wr(PCG_OFS_DEEP_UNIT, du_r);
      v = $urandom;
      run_r = v[7:0];
      wr(PCG_OFS_RUN_PORT, {24'h0, run_r});
      @(posedge mclk);
      cmp_gate(exp_gate(), exp_mode());
      for (int m = 0; m < 8; m++) begin
        auto_r = m[2];
        wr(PCG_OFS_RUN_CFG, {31'h0, auto_r});
        sleep_req <= m[0];
        deep_sleep_req <= m[1];
        repeat (3) @(posedge mclk);
        cmp_gate(exp_gate(), exp_mode());
        sweep();
      end
    end
    // second reset with every register loaded
    @(posedge mclk);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    run_unit_gate <= 4'h0;
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp_gate('0, PCG_MODE_RUN);
    for (int k = 0; k < 5; k++) begin
      rd(ofs[k], 32'h0000_0000);
    end
    repeat (4) @(posedge mclk);
    if (rd_q.size() != 0 || ans_q.size() != 0) bad("answers missing");
    end_sim();
  end
endmodule : tb_top
